/* File: charger_prot_pkg.sv */
// Constants and types of the charger protection block.
// Assumes a 25 MHz system clock.
package charger_prot_pkg;

	// Timing.
	localparam int SYS_CLK_MHZ = 25;
	localparam int IRQ_PULSE_NS = 256000;
	localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int BOOST_RETRY_NS = 1000000;
	localparam int BOOST_RETRY_CYC = (BOOST_RETRY_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam logic [2:0] BOOST_RETRY_MAX = 3'h7;
	localparam int CNT_W = 16;

	// Serial port.
	localparam logic [7:0] SLAVE_ADDR_W = 8'hD6;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [3:0] DONE_SLOT = 4'h9;

	// Register indices.
	localparam logic [7:0] REG_INPUT_LIMIT = 8'h00;
	localparam logic [7:0] REG_CTRL = 8'h01;
	localparam logic [7:0] REG_PROT_CFG = 8'h06;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_FAULT = 8'h09;

	// Reset values.
	localparam logic [7:0] INPUT_LIMIT_RST = 8'h17;
	localparam logic [7:0] CTRL_RST = 8'h1A;
	localparam logic [7:0] PROT_CFG_RST = 8'h00;

	// Field positions.
	localparam int HIZ_BIT = 7;
	localparam int STATPIN_HI = 6;
	localparam int STATPIN_LO = 5;
	localparam int ILIM_HI = 4;
	localparam int BOOST_EN_BIT = 5;
	localparam int CHG_EN_BIT = 4;
	localparam int OVSEL_HI = 7;
	localparam int OVSEL_LO = 6;
	localparam int TLIM_BIT = 0;

	// Field codes.
	localparam logic [1:0] CHG_FLT_NONE = 2'h0;
	localparam logic [1:0] CHG_FLT_INPUT = 2'h1;
	localparam logic [1:0] CHG_FLT_THERMAL = 2'h2;
	localparam logic [1:0] STATPIN_ON = 2'h0;
	localparam logic [1:0] CUR_FAST = 2'h0;
	localparam logic [1:0] CUR_PRECHG = 2'h1;
	localparam logic [1:0] CUR_TRICKLE = 2'h2;

	// Synchroniser vector positions.
	localparam int AI_VBUS_OV = 0;
	localparam int AI_SYS_OV = 1;
	localparam int AI_BST_SHORT = 2;
	localparam int AI_BST_OV = 3;
	localparam int AI_TJ_90 = 4;
	localparam int AI_TJ_110 = 5;
	localparam int AI_TJ_SHUT = 6;
	localparam int AI_TJ_HYS = 7;
	localparam int AI_BAT_OV = 8;
	localparam int AI_BAT_DPL = 9;
	localparam int AI_VBUS_OK = 10;
	localparam int AI_BAT_SHORT = 11;
	localparam int AI_BAT_LOWV = 12;
	localparam int AI_SYS_OC = 13;
	localparam int AI_SHIP_EXIT = 14;
	localparam int AI_SRC_DONE = 15;
	localparam int AI_ILIM_LO = 16;
	localparam int N_ASYNC = 21;

	typedef enum logic [2:0] {
		B_IDLE = 3'b001,
		B_RUN = 3'b010,
		B_WAIT = 3'b100
	} boost_state_t;

	typedef enum logic [5:0] {
		L_IDLE = 6'b000001,
		L_ADDR = 6'b000010,
		L_REG = 6'b000100,
		L_WDAT = 6'b001000,
		L_WAIT = 6'b010000,
		L_RDAT = 6'b100000
	} link_state_t;

endpackage : charger_prot_pkg

/* File: charger_protection_fault_ctrl.sv */
// Charger protection, fault reporting and serial register port.
// Assumes asynchronous comparator flags and an oversampling link clock.
//
// Function
// - Input overvoltage stops switching, sets charge fault 01.
// - Switching resumes alone once input overvoltage ends.
// - Input overvoltage sends one interrupt pulse.
// - Each interrupt pulse is low for 256 us.
// - No new fault pulses until faults are read and cleared.
// - System voltage 14% over target stops the converter.
// - Boost output short stops boost; up to seven retries.
// - Failed retries clear boost enable, set boost fault, interrupt.
// - Boost overvoltage stops boost, clears enable, sets boost fault, interrupts.
// - Above 110 C, or 90 C by a bit, charge current drops.
// - Thermal regulation: no termination, half-rate timer, status bit high.
// - Above 160 C switch and converter stop, fault set, interrupt.
// - Thirty degrees below shutdown operation resumes; boost waits for host.
// - Battery 7% over target stops charge, sets fault, interrupts.
// - Depleted battery opens battery switch until input appears.
// - Recovery: trickle below short threshold, precharge below low threshold.
// - System overcurrent latches battery switch off until shipping exit or input appears.
// - Slave answers address D6H at standard and fast rates.
// - Address with write bit, register index, one data byte.
// - Input current limit: 5 bits, default 2400 mA, set by detection.
// - Status pin on for code 00, floated otherwise.
`timescale 1ns/1ps
module charger_protection_fault_ctrl import charger_prot_pkg::*; #(
	parameter int IRQ_CYCLES = IRQ_PULSE_CYC,
	parameter int RETRY_CYCLES = BOOST_RETRY_CYC
) (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic en_i,
	input wire logic clk_link_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic vbus_ov_i,
	input wire logic sys_ov_i,
	input wire logic boost_short_i,
	input wire logic boost_ov_i,
	input wire logic tj_above_90_i,
	input wire logic tj_above_110_i,
	input wire logic tj_above_shut_i,
	input wire logic tj_above_hys_i,
	input wire logic bat_ov_i,
	input wire logic bat_depleted_i,
	input wire logic vbus_present_i,
	input wire logic bat_below_short_i,
	input wire logic bat_below_lowv_i,
	input wire logic sys_oc_i,
	input wire logic ship_exit_i,
	input wire logic src_detect_done_i,
	input wire logic [4:0] src_ilim_i,
	output logic scl_o,
	output logic scl_oe_o,
	output logic sda_o,
	output logic sda_oe_o,
	output logic host_irq_n_o,
	output logic switching_en_o,
	output logic charge_en_o,
	output logic boost_run_o,
	output logic battery_switch_o,
	output logic charge_current_reduce_o,
	output logic termination_en_o,
	output logic timer_half_rate_o,
	output logic [1:0] charge_current_mode_o,
	output logic stat_pin_en_o,
	output logic high_impedance_enable_o,
	output logic [4:0] input_current_limit_o,
	output logic [1:0] input_ov_threshold_sel_o,
	output logic thermal_limit_sel_o
);

	if (IRQ_CYCLES < 1 || IRQ_CYCLES >= 2 ** CNT_W || RETRY_CYCLES < 1 ||
		RETRY_CYCLES >= 2 ** CNT_W) begin : g_param_check
		$error("Cycle counts out of range.");
	end

	// Comparator flag synchronisers.
	logic [N_ASYNC-1:0] async_raw;
	logic [N_ASYNC-1:0] sync1_q;
	logic [N_ASYNC-1:0] sync2_q;
	logic [N_ASYNC-1:0] prev_q;

	assign async_raw = {src_ilim_i, src_detect_done_i, ship_exit_i, sys_oc_i,
		bat_below_lowv_i, bat_below_short_i, vbus_present_i, bat_depleted_i, bat_ov_i,
		tj_above_hys_i, tj_above_shut_i, tj_above_110_i, tj_above_90_i, boost_ov_i,
		boost_short_i, sys_ov_i, vbus_ov_i};

	for (genvar g = 0; g < N_ASYNC; g++) begin : g_sync
		always_ff @(posedge clk_sys_i or negedge rstn_i) begin
			if (!rstn_i) begin
				sync1_q[g] <= 1'b0;
				sync2_q[g] <= 1'b0;
			end else if (en_i) begin
				sync1_q[g] <= async_raw[g];
				sync2_q[g] <= sync1_q[g];
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prev_q <= '0;
		end else if (en_i) begin
			prev_q <= sync2_q;
		end
	end

	// Link toggles into the system domain.
	logic [1:0] tsync1_q;
	logic [1:0] tsync2_q;
	logic [1:0] tsync3_q;
	logic wr_tgl_q;
	logic rd_tgl_q;
	logic [7:0] wr_addr_q;
	logic [7:0] wr_data_q;
	logic [7:0] ptr_q;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tsync1_q <= 2'h0;
			tsync2_q <= 2'h0;
			tsync3_q <= 2'h0;
		end else if (en_i) begin
			tsync1_q <= {rd_tgl_q, wr_tgl_q};
			tsync2_q <= tsync1_q;
			tsync3_q <= tsync2_q;
		end
	end

	logic wr_evt;
	logic rd_evt;
	assign wr_evt = tsync2_q[0] ^ tsync3_q[0];
	assign rd_evt = tsync2_q[1] ^ tsync3_q[1];

	// Registers and protection state.
	logic [7:0] input_limit_q;
	logic [7:0] ctrl_q;
	logic [7:0] cfg_q;
	logic flt_boost_q;
	logic [1:0] flt_chg_q;
	logic flt_bat_q;
	logic fault_blk_q;
	logic tshut_q;
	logic ocp_q;
	logic dpl_q;
	logic [CNT_W-1:0] irq_cnt_q;
	logic [CNT_W-1:0] retry_cnt_q;
	logic [2:0] retry_q;
	boost_state_t bst_q;
	logic [7:0] rd_data_q;
	logic rd_ack_q;

	logic vbus_ov, sys_ov, bst_short, bst_ov, tj_shut, bat_ov, vbus_ok;
	logic boost_mode, charge_mode, thermal_limit_sel_active, buck_ok;
	logic in_ov_rise, tshut_rise, bat_ov_rise, src_done_rise, vbus_ok_rise, ship_rise;
	logic boost_fail, boost_ov_trip, boost_clear, boost_reenable;
	logic fault_evt, fault_rd, live_none, irq_start;
	logic [7:0] rd_mux;

	assign vbus_ov = sync2_q[AI_VBUS_OV];
	assign sys_ov = sync2_q[AI_SYS_OV];
	assign bst_short = sync2_q[AI_BST_SHORT];
	assign bst_ov = sync2_q[AI_BST_OV];
	assign tj_shut = sync2_q[AI_TJ_SHUT];
	assign bat_ov = sync2_q[AI_BAT_OV];
	assign vbus_ok = sync2_q[AI_VBUS_OK];
	assign in_ov_rise = vbus_ov & ~prev_q[AI_VBUS_OV];
	assign tshut_rise = tj_shut & ~prev_q[AI_TJ_SHUT];
	assign bat_ov_rise = bat_ov & ~prev_q[AI_BAT_OV];
	assign src_done_rise = sync2_q[AI_SRC_DONE] & ~prev_q[AI_SRC_DONE];
	assign vbus_ok_rise = vbus_ok & ~prev_q[AI_VBUS_OK];
	assign ship_rise = sync2_q[AI_SHIP_EXIT] & ~prev_q[AI_SHIP_EXIT];

	assign boost_mode = ctrl_q[BOOST_EN_BIT];
	assign charge_mode = ~boost_mode & vbus_ok;
	assign thermal_limit_sel_active = charge_mode & (cfg_q[TLIM_BIT] ? sync2_q[AI_TJ_90] :
		sync2_q[AI_TJ_110]);
	assign buck_ok = charge_mode & ~vbus_ov & ~sys_ov & ~tshut_q & ~input_limit_q[HIZ_BIT];

	assign boost_ov_trip = (bst_q == B_RUN) & boost_mode & bst_ov;
	assign boost_fail = (bst_q == B_RUN) & boost_mode & ~bst_ov & bst_short &
		(retry_q == BOOST_RETRY_MAX);
	assign boost_clear = boost_fail | boost_ov_trip | (tshut_rise & boost_mode);
	assign boost_reenable = wr_evt & (wr_addr_q == REG_CTRL) & wr_data_q[BOOST_EN_BIT] &
		~ctrl_q[BOOST_EN_BIT];

	assign fault_evt = (~boost_mode & in_ov_rise) | boost_clear | (~boost_mode & tshut_rise) |
		(charge_mode & bat_ov_rise);
	assign fault_rd = rd_evt & (ptr_q == REG_FAULT);
	assign live_none = ~vbus_ov & ~tj_shut & ~bat_ov & ~flt_boost_q;
	assign irq_start = (fault_evt & ~fault_blk_q) | src_done_rise;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			input_limit_q <= INPUT_LIMIT_RST;
			ctrl_q <= CTRL_RST;
			cfg_q <= PROT_CFG_RST;
		end else if (en_i) begin
			if (wr_evt && wr_addr_q == REG_INPUT_LIMIT) begin
				input_limit_q <= wr_data_q;
			end
			if (src_done_rise) begin
				input_limit_q[ILIM_HI:0] <= sync2_q[AI_ILIM_LO+ILIM_HI:AI_ILIM_LO];
			end
			if (wr_evt && wr_addr_q == REG_CTRL) begin
				ctrl_q <= wr_data_q;
			end
			if (boost_clear) begin
				ctrl_q[BOOST_EN_BIT] <= 1'b0;
			end
			if (wr_evt && wr_addr_q == REG_PROT_CFG) begin
				cfg_q <= wr_data_q;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			flt_boost_q <= 1'b0;
			flt_chg_q <= CHG_FLT_NONE;
			flt_bat_q <= 1'b0;
			fault_blk_q <= 1'b0;
		end else if (en_i) begin
			if (boost_reenable) begin
				flt_boost_q <= 1'b0;
			end
			if (boost_clear) begin
				flt_boost_q <= 1'b1;
			end
			if (fault_rd) begin
				flt_chg_q <= vbus_ov ? CHG_FLT_INPUT : (tj_shut ? CHG_FLT_THERMAL : CHG_FLT_NONE);
				flt_bat_q <= bat_ov;
			end
			if (~boost_mode && tshut_rise) begin
				flt_chg_q <= CHG_FLT_THERMAL;
			end
			if (~boost_mode && in_ov_rise) begin
				flt_chg_q <= CHG_FLT_INPUT;
			end
			if (charge_mode && bat_ov_rise) begin
				flt_bat_q <= 1'b1;
			end
			if (fault_rd && live_none) begin
				fault_blk_q <= 1'b0;
			end
			if (fault_evt) begin
				fault_blk_q <= 1'b1;
			end
		end
	end

	// Interrupt pulse timer.
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_cnt_q <= '0;
			host_irq_n_o <= 1'b1;
		end else if (en_i) begin
			if (irq_start && irq_cnt_q == '0) begin
				irq_cnt_q <= CNT_W'(IRQ_CYCLES);
				host_irq_n_o <= 1'b0;
			end else if (irq_cnt_q == CNT_W'(1)) begin
				irq_cnt_q <= '0;
				host_irq_n_o <= 1'b1;
			end else if (irq_cnt_q != '0) begin
				irq_cnt_q <= irq_cnt_q - CNT_W'(1);
			end
		end
	end

	// Protection latches.
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tshut_q <= 1'b0;
			ocp_q <= 1'b0;
			dpl_q <= 1'b0;
		end else if (en_i) begin
			if (tj_shut) begin
				tshut_q <= 1'b1;
			end else if (!sync2_q[AI_TJ_HYS]) begin
				tshut_q <= 1'b0;
			end
			if (ship_rise || vbus_ok_rise) begin
				ocp_q <= 1'b0;
			end
			if (sync2_q[AI_SYS_OC]) begin
				ocp_q <= 1'b1;
			end
			if (vbus_ok) begin
				dpl_q <= 1'b0;
			end else if (sync2_q[AI_BAT_DPL]) begin
				dpl_q <= 1'b1;
			end
		end
	end

	// Boost short retry sequencer.
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bst_q <= B_IDLE;
			retry_q <= 3'h0;
			retry_cnt_q <= '0;
		end else if (en_i) begin
			case (bst_q)
				B_IDLE: begin
					if (boost_mode && !tshut_q) begin
						bst_q <= B_RUN;
						retry_q <= 3'h0;
					end
				end
				B_RUN: begin
					if (!boost_mode || tshut_q || bst_ov || boost_fail) begin
						bst_q <= B_IDLE;
					end else if (bst_short) begin
						bst_q <= B_WAIT;
						retry_q <= retry_q + 3'h1;
						retry_cnt_q <= CNT_W'(RETRY_CYCLES);
					end
				end
				B_WAIT: begin
					if (!boost_mode || tshut_q) begin
						bst_q <= B_IDLE;
					end else if (retry_cnt_q == CNT_W'(1)) begin
						bst_q <= B_RUN;
					end else begin
						retry_cnt_q <= retry_cnt_q - CNT_W'(1);
					end
				end
				default: begin
					bst_q <= B_IDLE;
				end
			endcase
		end
	end

	// Register read answer.
	always_comb begin
		if (ptr_q == REG_INPUT_LIMIT) begin
			rd_mux = input_limit_q;
		end else if (ptr_q == REG_CTRL) begin
			rd_mux = ctrl_q;
		end else if (ptr_q == REG_PROT_CFG) begin
			rd_mux = cfg_q;
		end else if (ptr_q == REG_STATUS) begin
			rd_mux = {6'h00, thermal_limit_sel_active, bst_q == B_RUN};
		end else if (ptr_q == REG_FAULT) begin
			rd_mux = {1'b0, flt_boost_q, flt_chg_q, flt_bat_q, 3'h0};
		end else begin
			rd_mux = 8'h00;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rd_data_q <= 8'h00;
			rd_ack_q <= 1'b0;
		end else if (en_i && rd_evt) begin
			rd_data_q <= rd_mux;
			rd_ack_q <= ~rd_ack_q;
		end
	end

	// Registered outputs toward the power stage.
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			switching_en_o <= 1'b0;
			charge_en_o <= 1'b0;
			boost_run_o <= 1'b0;
			battery_switch_o <= 1'b0;
			charge_current_reduce_o <= 1'b0;
			termination_en_o <= 1'b1;
			timer_half_rate_o <= 1'b0;
			charge_current_mode_o <= CUR_FAST;
			stat_pin_en_o <= 1'b0;
			high_impedance_enable_o <= 1'b0;
			input_current_limit_o <= 5'h00;
			input_ov_threshold_sel_o <= 2'h0;
			thermal_limit_sel_o <= 1'b0;
		end else if (en_i) begin
			switching_en_o <= buck_ok | (bst_q == B_RUN & ~tshut_q);
			charge_en_o <= buck_ok & ctrl_q[CHG_EN_BIT] & ~bat_ov;
			boost_run_o <= (bst_q == B_RUN) & ~tshut_q;
			battery_switch_o <= ~(tshut_q | ocp_q | dpl_q);
			charge_current_reduce_o <= thermal_limit_sel_active;
			termination_en_o <= ~thermal_limit_sel_active;
			timer_half_rate_o <= thermal_limit_sel_active;
			charge_current_mode_o <= sync2_q[AI_BAT_SHORT] ? CUR_TRICKLE :
				(sync2_q[AI_BAT_LOWV] ? CUR_PRECHG : CUR_FAST);
			stat_pin_en_o <= input_limit_q[STATPIN_HI:STATPIN_LO] == STATPIN_ON;
			high_impedance_enable_o <= input_limit_q[HIZ_BIT];
			input_current_limit_o <= input_limit_q[ILIM_HI:0];
			input_ov_threshold_sel_o <= cfg_q[OVSEL_HI:OVSEL_LO];
			thermal_limit_sel_o <= cfg_q[TLIM_BIT];
		end
	end

	// Link domain inputs pass two flip-flops.
	logic [3:0] lsync1_q;
	logic [3:0] lsync2_q;
	logic [3:0] lprev_q;
	link_state_t lst_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] shift_q;

	always_ff @(posedge clk_link_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lsync1_q <= 4'h3;
			lsync2_q <= 4'h3;
			lprev_q <= 4'h3;
		end else begin
			lsync1_q <= {rd_ack_q, en_i, sda_i, scl_i};
			lsync2_q <= lsync1_q;
			lprev_q <= lsync2_q;
		end
	end

	logic scl, sda, len, scl_rise, scl_fall, bus_start, bus_stop, ack_evt;
	assign scl = lsync2_q[0];
	assign sda = lsync2_q[1];
	assign len = lsync2_q[2];
	assign scl_rise = scl & ~lprev_q[0];
	assign scl_fall = ~scl & lprev_q[0];
	assign bus_start = scl & lprev_q[0] & ~sda & lprev_q[1];
	assign bus_stop = scl & lprev_q[0] & sda & ~lprev_q[1];
	assign ack_evt = lsync2_q[3] ^ lprev_q[3];

	always_ff @(posedge clk_link_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lst_q <= L_IDLE;
			bit_cnt_q <= 4'h0;
			shift_q <= 8'h00;
			ptr_q <= 8'h00;
			wr_addr_q <= 8'h00;
			wr_data_q <= 8'h00;
			wr_tgl_q <= 1'b0;
			rd_tgl_q <= 1'b0;
			sda_oe_o <= 1'b0;
			scl_oe_o <= 1'b0;
		end else if (len) begin
			if (bus_start) begin
				lst_q <= L_ADDR;
				bit_cnt_q <= 4'h0;
				sda_oe_o <= 1'b0;
				scl_oe_o <= 1'b0;
			end else if (bus_stop) begin
				lst_q <= L_IDLE;
				sda_oe_o <= 1'b0;
				scl_oe_o <= 1'b0;
			end else begin
				case (lst_q)
					L_ADDR, L_REG, L_WDAT: begin
						if (scl_rise) begin
							bit_cnt_q <= bit_cnt_q + 4'h1;
							if (bit_cnt_q < ACK_SLOT) begin
								shift_q <= {shift_q[6:0], sda};
							end
						end else if (scl_fall && bit_cnt_q == ACK_SLOT) begin
							if (lst_q == L_ADDR) begin
								if ({shift_q[7:1], 1'b0} == SLAVE_ADDR_W) begin
									sda_oe_o <= 1'b1;
								end else begin
									lst_q <= L_IDLE;
								end
							end else if (lst_q == L_REG) begin
								ptr_q <= shift_q;
								sda_oe_o <= 1'b1;
							end else begin
								wr_addr_q <= ptr_q;
								wr_data_q <= shift_q;
								wr_tgl_q <= ~wr_tgl_q;
								sda_oe_o <= 1'b1;
							end
						end else if (scl_fall && bit_cnt_q == DONE_SLOT) begin
							sda_oe_o <= 1'b0;
							bit_cnt_q <= 4'h0;
							if (lst_q == L_ADDR && shift_q[0]) begin
								lst_q <= L_WAIT;
								scl_oe_o <= 1'b1;
								rd_tgl_q <= ~rd_tgl_q;
							end else if (lst_q == L_ADDR) begin
								lst_q <= L_REG;
							end else if (lst_q == L_REG) begin
								lst_q <= L_WDAT;
							end else begin
								lst_q <= L_IDLE;
							end
						end
					end
					L_WAIT: begin
						if (ack_evt) begin
							shift_q <= rd_data_q;
							sda_oe_o <= ~rd_data_q[7];
							scl_oe_o <= 1'b0;
							bit_cnt_q <= 4'h0;
							lst_q <= L_RDAT;
						end
					end
					L_RDAT: begin
						if (scl_rise) begin
							bit_cnt_q <= bit_cnt_q + 4'h1;
						end else if (scl_fall && bit_cnt_q < ACK_SLOT) begin
							shift_q <= {shift_q[6:0], 1'b0};
							sda_oe_o <= ~shift_q[6];
						end else if (scl_fall && bit_cnt_q == ACK_SLOT) begin
							sda_oe_o <= 1'b0;
						end else if (scl_fall && bit_cnt_q == DONE_SLOT) begin
							lst_q <= L_IDLE;
							bit_cnt_q <= 4'h0;
						end
					end
					default: begin
						sda_oe_o <= 1'b0;
					end
				endcase
			end
		end
	end

	// Open-drain pins only ever pull low.
	always_ff @(posedge clk_link_i or negedge rstn_i) begin
		if (!rstn_i) begin
			scl_o <= 1'b0;
			sda_o <= 1'b0;
		end else begin
			scl_o <= 1'b0;
			sda_o <= 1'b0;
		end
	end

endmodule : charger_protection_fault_ctrl

/* File: host_bus.sv */
// Host model driving the two-wire register bus.
// Assumes the bench resolves each wire as a wired-AND.
`timescale 1ns/1ps
module host_bus (
	input wire logic scl_i,
	input wire logic sda_i,
	output logic scl_oe_o,
	output logic sda_oe_o
);
	localparam int Q = 700;
	logic [7:0] sh_q;
	initial begin
		scl_oe_o = 1'b0;
		sda_oe_o = 1'b0;
	end
	task automatic bit_io(input logic b);
		sda_oe_o = !b;
		#Q scl_oe_o = 1'b0;
		wait (scl_i === 1'b1);
		#Q sh_q = {sh_q[6:0], sda_i};
		scl_oe_o = 1'b1;
		#Q;
	endtask : bit_io
	task automatic start();
		sda_oe_o = 1'b0;
		#Q scl_oe_o = 1'b0;
		wait (scl_i === 1'b1);
		#Q sda_oe_o = 1'b1;
		#Q scl_oe_o = 1'b1;
		#Q;
	endtask : start
	task automatic stop();
		sda_oe_o = 1'b1;
		#Q scl_oe_o = 1'b0;
		#Q sda_oe_o = 1'b0;
		#Q;
	endtask : stop
	task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic ack);
		for (int i = 7; i >= 0; i--) bit_io(d[i]);
		r = sh_q;
		bit_io(1'b1);
		ack = !sh_q[0];
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic k0, k1, k2;
		start();
		xfer(8'hD6, r, k0);
		xfer(a, r, k1);
		xfer(d, r, k2);
		stop();
		ok = k0 & k1 & k2;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic [7:0] r;
		logic k;
		start();
		xfer(8'hD6, r, k);
		xfer(a, r, k);
		start();
		xfer(8'hD7, r, k);
		xfer(8'hFF, d, k);
		stop();
	endtask : rd
endmodule : host_bus

/* File: charger_protection_fault_ctrl_chk.sv */
// Port checks of the charger protection block.
// Assumes en_i held high.
`timescale 1ns/1ps
module charger_protection_fault_ctrl_chk #(
	parameter int IRQ_CYCLES = 20
) (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic vbus_ov_i,
	input wire logic sys_ov_i,
	input wire logic tj_above_shut_i,
	input wire logic bat_ov_i,
	input wire logic bat_depleted_i,
	input wire logic vbus_present_i,
	input wire logic sys_oc_i,
	input wire logic ship_exit_i,
	input wire logic host_irq_n_o,
	input wire logic switching_en_o,
	input wire logic charge_en_o,
	input wire logic boost_run_o,
	input wire logic battery_switch_o,
	input wire logic charge_current_reduce_o,
	input wire logic termination_en_o,
	input wire logic timer_half_rate_o
);
	logic [15:0] low_q;
	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (!rstn_i);
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			low_q <= 16'h0000;
		end else begin
			low_q <= host_irq_n_o ? 16'h0000 : low_q + 16'h0001;
		end
	end
	property p_irq_len;
		$rose(host_irq_n_o) |-> low_q == 16'(IRQ_CYCLES);
	endproperty
	a_irq_len: assert property (p_irq_len) else $error("irq len");
	property p_ov_stop;
		(vbus_ov_i && !boost_run_o) [*4] |-> !switching_en_o;
	endproperty
	a_ov_stop: assert property (p_ov_stop) else $error("ov switching");
	property p_sys_ov;
		(sys_ov_i && !boost_run_o) [*4] |-> !switching_en_o;
	endproperty
	a_sys_ov: assert property (p_sys_ov) else $error("sys ov");
	property p_shut;
		tj_above_shut_i [*5] |-> !battery_switch_o && !switching_en_o;
	endproperty
	a_shut: assert property (p_shut) else $error("shutdown");
	property p_bat_ov;
		bat_ov_i [*4] |-> !charge_en_o;
	endproperty
	a_bat_ov: assert property (p_bat_ov) else $error("bat ov");
	property p_thermal;
		charge_current_reduce_o |-> !termination_en_o && timer_half_rate_o;
	endproperty
	a_thermal: assert property (p_thermal) else $error("thermal");
	property p_dpl;
		(bat_depleted_i && !vbus_present_i) [*5] |-> !battery_switch_o;
	endproperty
	a_dpl: assert property (p_dpl) else $error("depleted");
	property p_ocp;
		sys_oc_i [*4] ##1 !ship_exit_i [*6] |-> !battery_switch_o;
	endproperty
	a_ocp: assert property (p_ocp) else $error("oc latch");
	c_irq: cover property ($fell(host_irq_n_o));
	c_sw: cover property ($rose(battery_switch_o));
	c_boost: cover property ($fell(boost_run_o));
endmodule : charger_protection_fault_ctrl_chk
bind charger_protection_fault_ctrl charger_protection_fault_ctrl_chk #(.IRQ_CYCLES(IRQ_CYCLES))
	u_charger_protection_fault_ctrl_chk (.*);

/* File: charger_protection_fault_ctrl_tb.sv */
// Bench of the charger protection block.
// Assumes unrelated 25 MHz and 8 MHz clocks.
`timescale 1ns/1ps
module charger_protection_fault_ctrl_tb;
	import charger_prot_pkg::*;
	localparam int IRQ = 20;
	logic clk_sys_i, rstn_i, en_i, clk_link_i, vbus_ov_i, sys_ov_i, boost_short_i, boost_ov_i;
	logic tj_above_90_i, tj_above_110_i, tj_above_shut_i, tj_above_hys_i, bat_ov_i;
	logic bat_depleted_i, vbus_present_i, bat_below_short_i, bat_below_lowv_i, sys_oc_i;
	logic ship_exit_i, src_detect_done_i, scl_o, scl_oe_o, sda_o, sda_oe_o, host_irq_n_o;
	logic switching_en_o, charge_en_o, boost_run_o, battery_switch_o, charge_current_reduce_o;
	logic termination_en_o, timer_half_rate_o, stat_pin_en_o, high_impedance_enable_o;
	logic thermal_limit_sel_o, h_scl_oe, h_sda_oe, ok;
	logic [1:0] charge_current_mode_o, input_ov_threshold_sel_o;
	logic [4:0] src_ilim_i, input_current_limit_o;
	logic [7:0] d, n;
	wire logic scl_i = !(h_scl_oe | scl_oe_o);
	wire logic sda_i = !(h_sda_oe | sda_oe_o);
	int mismatches, checks, cycles;
	charger_protection_fault_ctrl #(.IRQ_CYCLES(IRQ), .RETRY_CYCLES(10))
		u_charger_protection_fault_ctrl (.*);
	host_bus u_host_bus (.scl_i(scl_i), .sda_i(sda_i), .scl_oe_o(h_scl_oe), .sda_oe_o(h_sda_oe));
	initial begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = !clk_sys_i;
	end
	initial begin
		clk_link_i = 1'b0;
		#17;
		forever #62.5 clk_link_i = !clk_link_i;
	end
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 80000) begin
			mismatches++;
			stop_test();
		end
	end
	task automatic cyc(input int c);
		repeat (c) @(posedge clk_sys_i);
		#1;
	endtask : cyc
	task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", s, exp, seen);
		end
	endtask : chk
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		u_host_bus.rd(a, d);
		chk("read", d, e);
	endtask : rdc
	task automatic irq(input int lim, input logic [7:0] e);
		int w;
		w = 0;
		n = 8'h00;
		while (host_irq_n_o === 1'b1 && w < lim) begin
			cyc(1);
			w++;
		end
		while (host_irq_n_o === 1'b0 && n < 8'hFF) begin
			cyc(1);
			n++;
		end
		chk("irq", n, e);
	endtask : irq
	task automatic t_regs();
		rdc(8'h00, 8'h17);
		chk("ilim", 8'(input_current_limit_o), 8'h17);
		chk("stat on", 8'(stat_pin_en_o), 8'h01);
		u_host_bus.wr(8'h00, 8'h7F, ok);
		chk("ack", 8'(ok), 8'h01);
		rdc(8'h00, 8'h7F);
		chk("ilim", 8'(input_current_limit_o), 8'h1F);
		chk("stat off", 8'(stat_pin_en_o), 8'h00);
		rdc(8'h03, 8'h00);
		{src_ilim_i, src_detect_done_i} = 6'h0B;
		irq(12, 8'(IRQ));
		chk("ilim det", 8'(input_current_limit_o), 8'h05);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_ov();
		vbus_ov_i = 1'b1;
		irq(12, 8'(IRQ));
		chk("ov stop", 8'(switching_en_o), 8'h00);
		vbus_ov_i = 1'b0;
		cyc(4);
		vbus_ov_i = 1'b1;
		irq(12, 8'h00);
		vbus_ov_i = 1'b0;
		cyc(6);
		chk("ov resume", 8'(switching_en_o), 8'h01);
		rdc(8'h09, 8'h10);
		rdc(8'h09, 8'h00);
		$display("t_ov done");
	endtask : t_ov
	task automatic t_heat();
		tj_above_110_i = 1'b1;
		cyc(6);
		chk("reduce", 8'(charge_current_reduce_o), 8'h01);
		chk("term", 8'(termination_en_o), 8'h00);
		chk("half", 8'(timer_half_rate_o), 8'h01);
		rdc(8'h08, 8'h02);
		tj_above_110_i = 1'b0;
		u_host_bus.wr(8'h06, 8'hC1, ok);
		chk("cfg", 8'({input_ov_threshold_sel_o, thermal_limit_sel_o}), 8'h07);
		tj_above_90_i = 1'b1;
		cyc(6);
		chk("reduce 90", 8'(charge_current_reduce_o), 8'h01);
		tj_above_90_i = 1'b0;
		tj_above_shut_i = 1'b1;
		tj_above_hys_i = 1'b1;
		irq(12, 8'(IRQ));
		chk("shut fet", 8'(battery_switch_o), 8'h00);
		tj_above_shut_i = 1'b0;
		cyc(6);
		chk("hys hold", 8'(battery_switch_o), 8'h00);
		tj_above_hys_i = 1'b0;
		cyc(6);
		chk("hys exit", 8'(battery_switch_o), 8'h01);
		rdc(8'h09, 8'h20);
		rdc(8'h09, 8'h00);
		$display("t_heat done");
	endtask : t_heat
	task automatic bfault();
		irq(300, 8'(IRQ));
		chk("boost off", 8'(boost_run_o), 8'h00);
		rdc(8'h01, 8'h1A);
		rdc(8'h09, 8'h40);
	endtask : bfault
	task automatic t_boost();
		u_host_bus.wr(8'h01, 8'h3A, ok);
		boost_short_i = 1'b1;
		bfault();
		boost_short_i = 1'b0;
		u_host_bus.wr(8'h01, 8'h3A, ok);
		rdc(8'h09, 8'h00);
		boost_ov_i = 1'b1;
		bfault();
		boost_ov_i = 1'b0;
		u_host_bus.wr(8'h01, 8'h3A, ok);
		u_host_bus.wr(8'h01, 8'h1A, ok);
		rdc(8'h09, 8'h00);
		$display("t_boost done");
	endtask : t_boost
	task automatic t_bat();
		bat_ov_i = 1'b1;
		irq(12, 8'(IRQ));
		chk("bat stop", 8'(charge_en_o), 8'h00);
		bat_ov_i = 1'b0;
		rdc(8'h09, 8'h08);
		vbus_present_i = 1'b0;
		bat_depleted_i = 1'b1;
		cyc(6);
		chk("dpl off", 8'(battery_switch_o), 8'h00);
		vbus_present_i = 1'b1;
		cyc(6);
		chk("dpl on", 8'(battery_switch_o), 8'h01);
		bat_depleted_i = 1'b0;
		bat_below_short_i = 1'b1;
		cyc(6);
		chk("trickle", 8'(charge_current_mode_o), 8'(CUR_TRICKLE));
		{bat_below_short_i, bat_below_lowv_i, sys_oc_i, sys_ov_i} = 4'h7;
		cyc(6);
		chk("prechg", 8'(charge_current_mode_o), 8'(CUR_PRECHG));
		chk("sys ov", 8'(switching_en_o), 8'h00);
		{bat_below_lowv_i, sys_oc_i, sys_ov_i} = 3'h0;
		cyc(6);
		chk("oc latch", 8'(battery_switch_o), 8'h00);
		ship_exit_i = 1'b1;
		cyc(6);
		chk("oc exit", 8'(battery_switch_o), 8'h01);
		$display("t_bat done");
	endtask : t_bat
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : stop_test
	initial begin
		{rstn_i, vbus_ov_i, sys_ov_i, boost_short_i, boost_ov_i, tj_above_90_i} = '0;
		{tj_above_110_i, tj_above_shut_i, tj_above_hys_i, bat_ov_i, bat_depleted_i} = '0;
		{bat_below_short_i, bat_below_lowv_i, sys_oc_i, ship_exit_i, src_detect_done_i} = '0;
		{src_ilim_i, mismatches, checks, cycles} = '0;
		en_i = 1'b1;
		vbus_present_i = 1'b1;
		repeat (12) @(posedge clk_sys_i);
		#1 rstn_i = 1'b1;
		cyc(10);
		t_regs();
		t_ov();
		t_heat();
		t_boost();
		t_bat();
		stop_test();
	end
endmodule : charger_protection_fault_ctrl_tb
